// File: hdl/mode_reg_bank.sv
/*
 * Mode register and multipurpose page bank of a memory device.
 * Link logic runs on the command clock; the temperature sample arrives from
 * the system clock domain through a toggle handshake.
 */
`default_nettype none
// Contract
// - Write command latency code per data rate applied to extra write latency.
// - Page 0 holds four writable patterns, defaults 55, 33, 0f, 00.
// - Page 1 read-only log of the command that failed parity.
// - Page 1 location 3: CRC, parity status, parity latency, low don't care.
// - Page 2 read-only snapshot of current mode settings.
// - Temperature readout enabled updates status, at most 32 ms old.
// - Temperature readout disabled freezes status bits.
// - Temperature code 00 slow, 01 nominal, 10 double, 11 reserved.
// - Mode four accepts repair, preamble, training, abort, monitor, refresh bits.
// - Chip select latency decodes 0,3,4,5,6,8; 110 and 111 reserved.
// - Register chosen by bank group 0 and bank; code 111 ignored.
// - Mode five accepts inversion, mask, parity mode, buffer, status bits.
// - Power down buffer bit ignored when nominal termination disabled.
// - Mode seven accesses have no effect.
module mode_reg_bank #(
    parameter int TEMP_CYC = mode_reg_pkg::TEMP_SAMPLE_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_temp_status,
    input wire logic i_cmd_clk,
    input wire logic i_cke,
    input wire mode_reg_pkg::ca_bus_t i_ca,
    input wire logic i_parity_fail,
    input wire logic i_crc_fail,
    input wire logic i_pat_wr,
    input wire logic [7:0] i_pat_data,
    input wire logic i_page_rd,
    output logic [7:0] o_page_data,
    output logic o_page_en,
    output logic [2:0] o_write_cmd_latency,
    output logic [3:0] o_cs_latency,
    output logic o_odt_pd_off,
    output logic [mode_reg_pkg::MR_W-1:0] o_mode_four,
    output logic [mode_reg_pkg::MR_W-1:0] o_mode_five,
    output logic [mode_reg_pkg::MR_W-1:0] o_mode_six
);
    import mode_reg_pkg::*;
    // =========================================================================
    // System side temperature sampler
    // =========================================================================
    logic [31:0] tcnt_r, tcnt_nxt;
    logic [1:0] tsamp_r, tsamp_nxt;
    logic ttog_r, ttog_nxt;
    always_comb begin
        tcnt_nxt = tcnt_r + 32'h1;
        tsamp_nxt = tsamp_r;
        ttog_nxt = ttog_r;
        // Sampling well inside the age limit keeps read data fresh.
        if (tcnt_r >= 32'(TEMP_CYC / 2 - 1)) begin
            tcnt_nxt = 32'h0;
            tsamp_nxt = i_temp_status;
            ttog_nxt = ~ttog_r;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tcnt_r <= 32'h0;
            tsamp_r <= TEMP_NOMINAL;
            ttog_r <= 1'b0;
        end else begin
            tcnt_r <= tcnt_nxt;
            tsamp_r <= tsamp_nxt;
            ttog_r <= ttog_nxt;
        end
    end
    // =========================================================================
    // Link side state
    // =========================================================================
    ca_bus_t ca_r;
    logic cke_prev_r;
    logic [2:0] tsync_r, tsync_nxt;
    logic [1:0] temp_r, temp_nxt;
    logic [MR_W-1:0] mr_r [0:6];
    logic [MR_W-1:0] mr_nxt [0:6];
    logic [7:0] pat_r [0:3];
    logic [7:0] pat_nxt [0:3];
    err_log_t log_r, log_nxt;
    logic [7:0] data_nxt;
    logic [2:0] wcl_nxt;
    logic [3:0] csl_nxt;
    logic mode_reg_set_cmd;
    logic [2:0] sel;
    logic [7:0] loc [0:3][0:3];
    logic [1:0] pg;
    logic [1:0] lc;
    // Tags on decode.
    assign mode_reg_set_cmd = i_cke && cke_prev_r && !i_ca.cs_n && i_ca.activate_low && !i_ca.ras_n
                 && !i_ca.cas_n && !i_ca.we_n;
    assign sel = {i_ca.bg[0], i_ca.ba};
    assign pg = mr_r[3][MR3_PAGE_LO +: 2];
    assign lc = i_ca.ba;
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            mr_nxt[i] = mr_r[i];
        end
        for (int i = 0; i < 4; i++) begin
            pat_nxt[i] = pat_r[i];
        end
        log_nxt = log_r;
        tsync_nxt = {tsync_r[1:0], ttog_r};
        temp_nxt = temp_r;
        // Frozen unless readout is enabled.
        if ((tsync_r[2] != tsync_r[1]) && mr_r[3][MR3_TEMP_EN]) begin
            temp_nxt = tsamp_r;
        end
        // Code 111 targets the buffer control word and is not answered.
        // Mode seven has no select code here, so it can never land.
        if (mode_reg_set_cmd && sel != SEL_BUFFER_CTRL) begin
            mr_nxt[sel] = i_ca.addr[MR_W-1:0];
            // Writing zero to the status bits clears the logged error.
            if (sel == SEL_MR5) begin
                if (!i_ca.addr[MR5_PERR]) begin
                    log_nxt.par_err = 1'b0;
                end
                if (!i_ca.addr[MR5_CRC_CLR]) begin
                    log_nxt.crc_err = 1'b0;
                end
            end
        end
        if (i_pat_wr && mr_r[3][MR3_PAGE_EN] && pg == 2'h0) begin
            pat_nxt[lc] = i_pat_data;
        end
        // Only the first failing command is kept until software clears status,
        // so a burst of errors leaves the original culprit visible. A failure in
        // the cycle of a clear still sets the status, so no error is lost.
        if (i_parity_fail) begin
            log_nxt.par_err = 1'b1;
            if (!log_r.par_err) begin
                log_nxt.cmd = ca_r;
            end
        end
        if (i_crc_fail) begin
            log_nxt.crc_err = 1'b1;
        end
    end
    // =========================================================================
    // Page contents
    // =========================================================================
    always_comb begin
        loc[0][0] = pat_r[0];
        loc[0][1] = pat_r[1];
        loc[0][2] = pat_r[2];
        loc[0][3] = pat_r[3];
        loc[1][0] = log_r.cmd.addr[7:0];
        loc[1][1] = {log_r.cmd.cas_n, log_r.cmd.we_n, log_r.cmd.addr[13:8]};
        loc[1][2] = {log_r.cmd.par, log_r.cmd.activate_low, log_r.cmd.bg, log_r.cmd.ba,
                     log_r.cmd.addr[17], log_r.cmd.ras_n};
        loc[1][3] = {log_r.crc_err, log_r.par_err, mr_r[5][2:0], 3'h0};
        // Snapshot of live settings.
        loc[2][0] = {mr_r[4][13], mr_r[4][5], mr_r[2][11], temp_r, mr_r[2][12],
                     mr_r[2][10:9]};
        loc[2][1] = {mr_r[6][6:0], mr_r[3][3]};
        loc[2][2] = {mr_r[0][6:4], mr_r[0][2], mr_r[0][12], mr_r[2][5:3]};
        loc[2][3] = {mr_r[1][10:8], mr_r[5][8:6], mr_r[1][2:1]};
        loc[3][0] = 8'h00;
        loc[3][1] = 8'h00;
        loc[3][2] = 8'h00;
        loc[3][3] = {4'h0, ACT_COUNT_CODE};
        data_nxt = o_page_data;
        if (i_page_rd && mr_r[3][MR3_PAGE_EN]) begin
            data_nxt = loc[pg][lc];
        end
        case (mr_r[3][10:9])
            2'h0: wcl_nxt = 3'h4;
            2'h1: wcl_nxt = 3'h5;
            2'h2: wcl_nxt = 3'h6;
            default: wcl_nxt = 3'h0;
        endcase
        case (mr_r[4][8:6])
            3'h0: csl_nxt = 4'h0;
            3'h1: csl_nxt = 4'h3;
            3'h2: csl_nxt = 4'h4;
            3'h3: csl_nxt = 4'h5;
            3'h4: csl_nxt = 4'h6;
            3'h5: csl_nxt = 4'h8;
            default: csl_nxt = 4'h0;
        endcase
    end
    always_ff @(posedge i_cmd_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ca_r <= '1;
            cke_prev_r <= 1'b0;
            tsync_r <= 3'h0;
            temp_r <= TEMP_NOMINAL;
            for (int i = 0; i < 7; i++) begin
                mr_r[i] <= '0;
            end
            pat_r[0] <= PAT0_RST;
            pat_r[1] <= PAT1_RST;
            pat_r[2] <= PAT2_RST;
            pat_r[3] <= PAT3_RST;
            log_r <= '0;
            o_page_data <= 8'h00;
            o_page_en <= 1'b0;
            o_write_cmd_latency <= 3'h0;
            o_cs_latency <= 4'h0;
            o_odt_pd_off <= 1'b0;
            o_mode_four <= '0;
            o_mode_five <= '0;
            o_mode_six <= '0;
        end else begin
            ca_r <= i_ca;
            cke_prev_r <= i_cke;
            tsync_r <= tsync_nxt;
            temp_r <= temp_nxt;
            for (int i = 0; i < 7; i++) begin
                mr_r[i] <= mr_nxt[i];
            end
            for (int i = 0; i < 4; i++) begin
                pat_r[i] <= pat_nxt[i];
            end
            log_r <= log_nxt;
            o_page_data <= data_nxt;
            o_page_en <= mr_r[3][MR3_PAGE_EN];
            o_write_cmd_latency <= wcl_nxt;
            o_cs_latency <= csl_nxt;
            o_odt_pd_off <= mr_r[5][MR5_ODT_PD] && (mr_r[1][10:8] != RTT_NOM_OFF);
            o_mode_four <= mr_r[4];
            o_mode_five <= mr_r[5];
            o_mode_six <= mr_r[6];
        end
    end
endmodule : mode_reg_bank
`default_nettype wire

// File: hdl/mode_reg_pkg.sv
/*
 * Constants and carriers for the mode register and multipurpose page bank.
 * Assumes a single command clock domain on the link side and a system clock
 * on the user side.
 */
`default_nettype none
package mode_reg_pkg;
    // =========================================================================
    // Command decode and register select
    // =========================================================================
    localparam logic [2:0] SEL_MR0 = 3'h0;
    localparam logic [2:0] SEL_MR1 = 3'h1;
    localparam logic [2:0] SEL_MR2 = 3'h2;
    localparam logic [2:0] SEL_MR3 = 3'h3;
    localparam logic [2:0] SEL_MR4 = 3'h4;
    localparam logic [2:0] SEL_MR5 = 3'h5;
    localparam logic [2:0] SEL_MR6 = 3'h6;
    localparam logic [2:0] SEL_BUFFER_CTRL = 3'h7;
    localparam int MR_W = 14;
    // =========================================================================
    // Page 0 defaults
    // =========================================================================
    localparam logic [7:0] PAT0_RST = 8'h55;
    localparam logic [7:0] PAT1_RST = 8'h33;
    localparam logic [7:0] PAT2_RST = 8'h0f;
    localparam logic [7:0] PAT3_RST = 8'h00;
    // =========================================================================
    // Field positions
    // =========================================================================
    localparam int MR3_PAGE_LO = 0;
    localparam int MR3_PAGE_EN = 2;
    localparam int MR3_TEMP_EN = 5;
    localparam int MR5_ODT_PD = 5;
    localparam int MR5_PERR = 4;
    localparam int MR5_CRC_CLR = 3;
    localparam logic [2:0] RTT_NOM_OFF = 3'h0;
    localparam logic [3:0] ACT_COUNT_CODE = 4'h0; // Arbitrary vendor code.
    localparam logic [1:0] TEMP_NOMINAL = 2'h1;
    // =========================================================================
    // Timing
    // =========================================================================
    localparam int TEMP_MAX_AGE_MS = 32;
    localparam int SYS_CLK_MHZ = 100;
    localparam int TEMP_SAMPLE_CYC = TEMP_MAX_AGE_MS * 1000 * SYS_CLK_MHZ;
    // =========================================================================
    // Carriers
    // =========================================================================
    typedef struct packed {
        logic cs_n;
        logic activate_low;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic par;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [17:0] addr;
    } ca_bus_t;
    typedef struct packed {
        logic crc_err;
        logic par_err;
        ca_bus_t cmd;
    } err_log_t;
endpackage : mode_reg_pkg
`default_nettype wire

// File: test/ddr_ctrl_model.sv
/*
 * Memory controller model: drives commands, page strobes and fault pulses.
 * Assumes the bench calls its tasks one at a time from one process.
 */
`default_nettype none
module ddr_ctrl_model
    import mode_reg_pkg::*;
(
    input wire logic i_cmd_clk,
    output logic o_cke,
    output mode_reg_pkg::ca_bus_t o_ca,
    output logic o_parity_fail,
    output logic o_crc_fail,
    output logic o_pat_wr,
    output logic [7:0] o_pat_data,
    output logic o_page_rd
);
    initial begin
        o_cke = 1'b1;
        o_ca = '1;
        {o_parity_fail, o_crc_fail, o_pat_wr, o_page_rd} = 4'h0;
        o_pat_data = 8'h00;
    end
    // A released bus shows the inverse of its last value with chip select held high, so stale data cannot pass.
    // The parity fault flag of st[3] follows one cycle after its command.
    task automatic send(input ca_bus_t c, input logic [3:0] st, input logic [7:0] d);
        @(posedge i_cmd_clk);
        o_ca <= c;
        {o_parity_fail, o_crc_fail, o_pat_wr, o_page_rd} <= {1'b0, st[2:0]};
        o_pat_data <= d;
        @(posedge i_cmd_clk);
        o_ca <= ~c | 28'h8000000;
        {o_parity_fail, o_crc_fail, o_pat_wr, o_page_rd} <= {st[3], 3'h0};
        o_pat_data <= ~d;
        @(posedge i_cmd_clk);
        o_parity_fail <= 1'b0;
    endtask : send
    task automatic mode_reg_set_cmd(input logic [2:0] s, input logic [13:0] op);
        ca_bus_t c;
        c = '0;
        c.activate_low = 1'b1;
        c.bg = {1'b0, s[2]};
        c.ba = s[1:0];
        c.addr = {4'h0, op};
        send(c, 4'h0, 8'h00);
    endtask : mode_reg_set_cmd
    task automatic page(input logic [1:0] loc, input logic wr, input logic [7:0] d);
        ca_bus_t c;
        c = '1;
        c.ba = loc;
        send(c, {2'b00, wr, !wr}, d);
    endtask : page
endmodule : ddr_ctrl_model
`default_nettype wire

// File: test/mode_reg_bank_asserts.sv
/*
 * Checker for mode_reg_bank: effects of mode register set commands at the outputs.
 * Assumes a bind to the top module; all checks run in the command clock domain.
 */
`default_nettype none
module mode_reg_bank_asserts
    import mode_reg_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_cmd_clk,
    input wire logic i_cke,
    input wire mode_reg_pkg::ca_bus_t i_ca,
    input wire logic [2:0] o_write_cmd_latency,
    input wire logic [3:0] o_cs_latency,
    input wire logic o_odt_pd_off,
    input wire logic o_page_en,
    input wire logic [mode_reg_pkg::MR_W-1:0] o_mode_four,
    input wire logic [mode_reg_pkg::MR_W-1:0] o_mode_five,
    input wire logic [mode_reg_pkg::MR_W-1:0] o_mode_six
);
    // Outputs follow the register one edge late, so effects are sampled two edges on.
    localparam logic [31:0] CAL_TAB = 32'h0086_5430;
    localparam logic [15:0] WCL_TAB = 16'h0654;
    logic cmd_ok;
    logic [2:0] sel;
    assign cmd_ok = !i_ca.cs_n && i_ca.activate_low && !i_ca.ras_n && !i_ca.cas_n && !i_ca.we_n;
    assign sel = {i_ca.bg[0], i_ca.ba};
    default clocking cb @(posedge i_cmd_clk); endclocking
    default disable iff (!i_rst_n);
    // ==================
    // Sequences
    // ==================
    sequence s_mrs(logic [2:0] s);
        i_cke && $past(i_cke) && cmd_ok && sel == s;
    endsequence
    property p_copy(logic [2:0] s, logic [13:0] q);
        s_mrs(s) |-> ##2 q == $past(i_ca.addr[13:0], 2);
    endproperty
    // ==================
    // Assertions
    // ==================
    mode_four_copy_a: assert property (p_copy(3'h4, o_mode_four))
        else $error("mode four copy wrong");
    mode_five_copy_a: assert property (p_copy(3'h5, o_mode_five))
        else $error("mode five copy wrong");
    mode_six_copy_a: assert property (p_copy(3'h6, o_mode_six))
        else $error("mode six copy wrong");
    mode_four_hold_a: assert property (!$stable(o_mode_four) |->
        $past(cmd_ok && sel == 3'h4, 2)) else $error("mode four changed without a set");
    sel_seven_ignored_a: assert property (s_mrs(3'h7) |-> ##2 $stable(o_mode_four)
        && $stable(o_mode_five) && $stable(o_mode_six)) else $error("select seven acted");
    cs_latency_a: assert property (s_mrs(3'h4) |->
        ##2 o_cs_latency == CAL_TAB[$past(i_ca.addr[8:6], 2) * 4 +: 4])
        else $error("cs latency decode wrong");
    write_latency_a: assert property (s_mrs(3'h3) |->
        ##2 o_write_cmd_latency == WCL_TAB[$past(i_ca.addr[10:9], 2) * 4 +: 3])
        else $error("write command latency wrong");
    page_enable_a: assert property (s_mrs(3'h3) |-> ##2 o_page_en == $past(i_ca.addr[2], 2))
        else $error("page enable wrong");
    odt_pd_ignored_a: assert property (s_mrs(3'h1) ##0 i_ca.addr[10:8] == 3'h0
        |-> ##2 !o_odt_pd_off) else $error("odt buffer bit not ignored");
endmodule : mode_reg_bank_asserts
bind mode_reg_bank mode_reg_bank_asserts u_mode_reg_bank_asserts (
    .i_sys_clk, .i_rst_n, .i_cmd_clk, .i_cke, .i_ca, .o_write_cmd_latency, .o_cs_latency,
    .o_odt_pd_off, .o_page_en, .o_mode_four, .o_mode_five, .o_mode_six
);
`default_nettype wire

// File: test/tb_mode_reg_bank.sv
/*
 * Self-checking bench for mode_reg_bank with a controller model on the link.
 * Assumes a free running command clock of 160 ns beside a 10 ns system clock.
 */
`default_nettype none
module tb_mode_reg_bank import mode_reg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] v; logic [7:0] m;} note_t;
    note_t notes[$];
    note_t n;
    logic sys_clk, cmd_clk, rst_n, cke, pf, cf, wr, rd;
    logic [1:0] temp, rd_q;
    logic [7:0] pd, pdo, r;
    logic [13:0] r6;
    ca_bus_t ca, fc;
    int mismatches, total_checks;
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        cmd_clk = 1'b0;
        #3;
        forever #80 cmd_clk = ~cmd_clk;
    end
    // Samples 1 us apart leave the command side several edges to take each one.
    mode_reg_bank #(.TEMP_CYC(200)) u_mode_reg_bank (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
        .i_temp_status(temp), .i_cmd_clk(cmd_clk), .i_cke(cke), .i_ca(ca), .i_parity_fail(pf),
        .i_crc_fail(cf), .i_pat_wr(wr), .i_pat_data(pd), .i_page_rd(rd), .o_page_data(pdo),
        .o_page_en(), .o_write_cmd_latency(), .o_cs_latency(), .o_odt_pd_off(),
        .o_mode_four(), .o_mode_five(), .o_mode_six());
    ddr_ctrl_model u_ddr_ctrl_model (.i_cmd_clk(cmd_clk), .o_cke(cke), .o_ca(ca),
        .o_parity_fail(pf), .o_crc_fail(cf), .o_pat_wr(wr), .o_pat_data(pd), .o_page_rd(rd));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rdx(input logic [1:0] loc, input logic [7:0] v, input logic [7:0] m);
        notes.push_back('{v, m});
        u_ddr_ctrl_model.page(loc, 1'b0, 8'h00);
    endtask : rdx
    task automatic report_and_stop();
        mismatches += notes.size();
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // Read data lands on the edge where the device takes the strobe; the check runs on the falling edge after the next rising edge.
    always @(posedge cmd_clk) rd_q <= {rd_q[0], rd};
    always @(negedge cmd_clk) begin
        if (rd_q[1] === 1'b1) begin
            n = notes.pop_front();
            chk("page data", pdo & n.m, n.v & n.m);
        end
    end
    initial begin
        #200us;
        mismatches++;
        report_and_stop();
    end
    initial begin
        temp = 2'h1;
        rst_n = 1'b0;
        r = 8'h38;
        repeat (8) @(posedge cmd_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge cmd_clk);
        u_ddr_ctrl_model.mode_reg_set_cmd(3'h3, 14'h0004);
        rdx(2'h0, 8'h55, 8'hff);
        rdx(2'h1, 8'h33, 8'hff);
        rdx(2'h2, 8'h0f, 8'hff);
        rdx(2'h3, 8'h00, 8'hff);
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            u_ddr_ctrl_model.page(i[1:0], 1'b1, r);
            rdx(i[1:0], r, 8'hff);
        end
        for (int i = 0; i < 6; i++) begin
            r = lfsr(r);
            u_ddr_ctrl_model.mode_reg_set_cmd(3'h4, {r[4:0], i[2:0], r[7:5], r[0], 2'b00});
            u_ddr_ctrl_model.mode_reg_set_cmd(3'h7, {r, 6'h2a});
        end
        for (int i = 0; i < 3; i++) u_ddr_ctrl_model.mode_reg_set_cmd(3'h3, {3'h0, i[1:0], 9'h000});
        u_ddr_ctrl_model.mode_reg_set_cmd(3'h5, 14'h0022);
        u_ddr_ctrl_model.mode_reg_set_cmd(3'h1, 14'h0000);
        u_ddr_ctrl_model.mode_reg_set_cmd(3'h1, 14'h0100);
        fc = {r, lfsr(r), lfsr(~r), 4'h5};
        fc.cs_n = 1'b0;
        fc.activate_low = 1'b0;
        u_ddr_ctrl_model.send(fc, 4'h8, 8'h00);
        u_ddr_ctrl_model.send('1, 4'h4, 8'h00);
        u_ddr_ctrl_model.mode_reg_set_cmd(3'h3, 14'h0005);
        u_ddr_ctrl_model.page(2'h0, 1'b1, ~fc.addr[7:0]);
        rdx(2'h0, fc.addr[7:0], 8'hff);
        rdx(2'h1, {fc.cas_n, fc.we_n, fc.addr[13:8]}, 8'hff);
        rdx(2'h2, {fc.par, fc.activate_low, fc.bg, fc.ba, fc.addr[17], fc.ras_n}, 8'hdd);
        rdx(2'h3, 8'hd0, 8'hf8);
        r6 = {1'b0, 3'h2, 2'b00, r[7:6], 1'b0, r[4:0]};
        u_ddr_ctrl_model.mode_reg_set_cmd(3'h6, r6);
        u_ddr_ctrl_model.mode_reg_set_cmd(3'h3, 14'h0026);
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            temp <= i[1:0];
            repeat (12) @(posedge cmd_clk);
            rdx(2'h0, {3'h0, i[1:0], 3'h0}, 8'h18);
        end
        rdx(2'h1, {r6[6:0], 1'b0}, 8'hff);
        u_ddr_ctrl_model.mode_reg_set_cmd(3'h3, 14'h0006);
        @(posedge sys_clk);
        temp <= 2'h1;
        repeat (12) @(posedge cmd_clk);
        rdx(2'h0, 8'h10, 8'h18);
        u_ddr_ctrl_model.mode_reg_set_cmd(3'h3, 14'h0007);
        rdx(2'h3, {4'h0, ACT_COUNT_CODE}, 8'h0f);
        repeat (4) @(posedge cmd_clk);
        report_and_stop();
    end
endmodule : tb_mode_reg_bank
`default_nettype wire
